// ===== design/prox_regs_pkg.sv
// constants for the proximity threshold and parameter mailbox register bank
// assumes one 250 MHz clock and a host on an open-drain two-wire serial bus
package prox_regs_pkg;
  localparam int unsigned CLOCK_MHZ = 250;
  localparam logic [6:0] SLAVE_ADDR = 7'h2A;  // arbitrary bus address
  localparam logic [7:0] OFF_PROX2_LOW = 8'h13;
  localparam logic [7:0] OFF_PROX2_HIGH = 8'h14;
  localparam logic [7:0] OFF_PROX3_LOW = 8'h15;
  localparam logic [7:0] OFF_PROX3_HIGH = 8'h16;
  localparam logic [7:0] OFF_PARAMETER_WRITE_MAILBOX = 8'h17;
  localparam logic [7:0] OFF_COMMAND = 8'h18;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam int unsigned LEGACY_SHIFT = 8;
  localparam int unsigned NUM_CHANNELS = 2;
  localparam int unsigned CH_PROX2 = 0;
  localparam int unsigned CH_PROX3 = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_PTR = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110
  } serial_state_t;
endpackage

// ===== design/sync2.sv
// two-flop synchroniser for one level coming from a pin
// assumes the input may change at any time relative to clock
module sync2
  import prox_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  input wire logic reset_level,
  output logic sync_out
);
  logic stage1_ff;

  // stage1_ff feeds only the second flop to give metastability a full cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_ff <= reset_level;
      sync_out <= reset_level;
    end else begin
      stage1_ff <= async_in;
      sync_out <= stage1_ff;
    end
  end
endmodule // sync2

// ===== design/threshold_compare.sv
// per-channel threshold comparator with a sticky event flag
// assumes measurement and control inputs come from logic on the same clock
module threshold_compare
  import prox_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] measurement,
  input wire logic measurement_valid,
  input wire logic [15:0] threshold,
  input wire logic autonomous_run,
  input wire logic flag_clear,
  output logic flag_ff
);
  logic crossing;

  // threshold is used as it stands, so a half-written update is compared too
  assign crossing = measurement_valid & autonomous_run & (measurement > threshold);

  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (crossing) begin
      flag_ff <= 1'b1;
    end else if (flag_clear) begin
      flag_ff <= 1'b0;
    end
  end
endmodule // threshold_compare

// ===== design/proximity_threshold_param_regs.sv
// serial register bank: two proximity thresholds, parameter and command mailboxes
// assumes open-drain scl/sda resolved outside, measurements on the local clock
module proximity_threshold_param_regs
  import prox_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic legacy_rev_strap,
  input wire logic autonomous_run,
  input wire logic [15:0] prox2_measurement,
  input wire logic prox2_measurement_valid,
  input wire logic [15:0] prox3_measurement,
  input wire logic prox3_measurement_valid,
  input wire logic [1:0] flag_clear,
  input wire logic [1:0] irq_enable,
  output logic [1:0] channel_flag,
  output logic int_n,
  output logic [15:0] second_channel_threshold,
  output logic [15:0] third_channel_threshold,
  output logic [7:0] parameter_write_mailbox,
  output logic [7:0] command_value,
  output logic command_strobe,
  output logic wake_request
);
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  serial_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic got_ptr_ff;
  logic more_ff;
  logic wr_fire;
  logic [7:0] rd_data;
  logic legacy_ff;
  logic strap_taken_ff;
  logic [1:0] strap_wait_ff;
  logic [7:0] prox2_threshold_low_ff;
  logic [7:0] prox2_threshold_high_ff;
  logic [7:0] prox3_threshold_low_ff;
  logic [7:0] prox3_threshold_high_ff;
  logic [7:0] param_ff;
  logic [15:0] nxt_prox2_threshold;
  logic [15:0] nxt_prox3_threshold;
  logic [15:0] meas_arr [NUM_CHANNELS];
  logic meas_valid_arr [NUM_CHANNELS];
  logic [15:0] thr_arr [NUM_CHANNELS];

  sync2 u_sync_scl (
    .clock(clock),
    .rst(rst),
    .async_in(scl_in),
    .reset_level(1'b1),
    .sync_out(scl_s)
  );

  sync2 u_sync_sda (
    .clock(clock),
    .rst(rst),
    .async_in(sda_in),
    .reset_level(1'b1),
    .sync_out(sda_s)
  );

  sync2 u_sync_strap (
    .clock(clock),
    .rst(rst),
    .async_in(legacy_rev_strap),
    .reset_level(1'b1),
    .sync_out(strap_s)
  );

  // strap caught once after release; changing it later has no effect
  // waits two cycles so the synchroniser shows the pin, not its reset level
  always_ff @(posedge clock) begin
    if (rst) begin
      legacy_ff <= 1'b0;
      strap_taken_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
    end else if (!strap_wait_ff[1]) begin
      strap_wait_ff <= {strap_wait_ff[0], 1'b1};
    end else if (!strap_taken_ff) begin
      legacy_ff <= strap_s;
      strap_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign wr_fire = (state_ff == ST_WDATA) & scl_fall & (bit_cnt_ff == BITS_PER_BYTE);

  // serial slave: address, pointer, then auto-incrementing data bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= BIT_CNT_ZERO;
      shift_ff <= RESET_BYTE;
      tx_ff <= RESET_BYTE;
      ptr_ff <= RESET_BYTE;
      rw_ff <= 1'b0;
      got_ptr_ff <= 1'b0;
      more_ff <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= BIT_CNT_ZERO;
      got_ptr_ff <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && bit_cnt_ff < BITS_PER_BYTE) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
            bit_cnt_ff <= BIT_CNT_ZERO;
            if (state_ff == ST_ADDR) begin
              if (shift_ff[7:1] == SLAVE_ADDR) begin
                rw_ff <= shift_ff[0];
                state_ff <= ST_ACK;
                sda_oe_n <= 1'b0;
              end else begin
                state_ff <= ST_IDLE;
              end
            end else if (state_ff == ST_PTR) begin
              ptr_ff <= shift_ff;
              got_ptr_ff <= 1'b1;
              state_ff <= ST_ACK;
              sda_oe_n <= 1'b0;
            end else begin
              ptr_ff <= ptr_ff + PTR_STEP;
              state_ff <= ST_ACK;
              sda_oe_n <= 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= BIT_CNT_ZERO;
            if (rw_ff) begin
              tx_ff <= rd_data;
              sda_oe_n <= rd_data[7];
              state_ff <= ST_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state_ff <= got_ptr_ff ? ST_WDATA : ST_PTR;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == BITS_PER_BYTE) begin
              sda_oe_n <= 1'b1;
              ptr_ff <= ptr_ff + PTR_STEP;
              state_ff <= ST_RACK;
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b0};
              sda_oe_n <= tx_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            more_ff <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_ff <= BIT_CNT_ZERO;
            if (more_ff) begin
              tx_ff <= rd_data;
              sda_oe_n <= rd_data[7];
              state_ff <= ST_RDATA;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // open drain: the data line is only ever pulled low
  always_ff @(posedge clock) begin
    sda_out <= 1'b0;
  end

  // byte registers; each byte lands on its own with no shadowing; legacy mode drops high-byte writes
  always_ff @(posedge clock) begin
    if (rst) begin
      prox2_threshold_low_ff <= RESET_BYTE;
      prox2_threshold_high_ff <= RESET_BYTE;
      prox3_threshold_low_ff <= RESET_BYTE;
      prox3_threshold_high_ff <= RESET_BYTE;
      param_ff <= RESET_BYTE;
    end else if (wr_fire) begin
      unique case (ptr_ff)
        OFF_PROX2_LOW: prox2_threshold_low_ff <= shift_ff;
        OFF_PROX2_HIGH: if (!legacy_ff) prox2_threshold_high_ff <= shift_ff;
        OFF_PROX3_LOW: prox3_threshold_low_ff <= shift_ff;
        OFF_PROX3_HIGH: if (!legacy_ff) prox3_threshold_high_ff <= shift_ff;
        OFF_PARAMETER_WRITE_MAILBOX: param_ff <= shift_ff;
        default: ;
      endcase
    end
  end

  // command mailbox: the only write that raises a wake request
  always_ff @(posedge clock) begin
    if (rst) begin
      command_value <= RESET_BYTE;
      command_strobe <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      command_strobe <= wr_fire & (ptr_ff == OFF_COMMAND);
      wake_request <= wr_fire & (ptr_ff == OFF_COMMAND);
      if (wr_fire && ptr_ff == OFF_COMMAND) begin
        command_value <= shift_ff;
      end
    end
  end

  always_comb begin
    unique case (ptr_ff)
      OFF_PROX2_LOW: rd_data = prox2_threshold_low_ff;
      OFF_PROX2_HIGH: rd_data = legacy_ff ? UNMAPPED_READ : prox2_threshold_high_ff;
      OFF_PROX3_LOW: rd_data = prox3_threshold_low_ff;
      OFF_PROX3_HIGH: rd_data = legacy_ff ? UNMAPPED_READ : prox3_threshold_high_ff;
      OFF_PARAMETER_WRITE_MAILBOX: rd_data = param_ff;
      OFF_COMMAND: rd_data = command_value;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  // legacy compressed byte expands by a fixed shift; coarse but monotonic
  always_comb begin
    if (legacy_ff) begin
      nxt_prox2_threshold = {RESET_BYTE, prox2_threshold_low_ff} << LEGACY_SHIFT;
      nxt_prox3_threshold = {RESET_BYTE, prox3_threshold_low_ff} << LEGACY_SHIFT;
    end else begin
      nxt_prox2_threshold = {prox2_threshold_high_ff, prox2_threshold_low_ff};
      nxt_prox3_threshold = {prox3_threshold_high_ff, prox3_threshold_low_ff};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      second_channel_threshold <= RESET_WORD;
      third_channel_threshold <= RESET_WORD;
      parameter_write_mailbox <= RESET_BYTE;
    end else begin
      second_channel_threshold <= nxt_prox2_threshold;
      third_channel_threshold <= nxt_prox3_threshold;
      parameter_write_mailbox <= param_ff;
    end
  end

  assign meas_arr[CH_PROX2] = prox2_measurement;
  assign meas_arr[CH_PROX3] = prox3_measurement;
  assign meas_valid_arr[CH_PROX2] = prox2_measurement_valid;
  assign meas_valid_arr[CH_PROX3] = prox3_measurement_valid;
  assign thr_arr[CH_PROX2] = second_channel_threshold;
  assign thr_arr[CH_PROX3] = third_channel_threshold;

  // one comparator per channel; each gates on autonomous_run, so no flag sets while paused
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
    threshold_compare u_cmp (
      .clock(clock),
      .rst(rst),
      .measurement(meas_arr[ch]),
      .measurement_valid(meas_valid_arr[ch]),
      .threshold(thr_arr[ch]),
      .autonomous_run(autonomous_run),
      .flag_clear(flag_clear[ch]),
      .flag_ff(channel_flag[ch])
    );
  end

  // pin goes low when any enabled flag is set
  always_ff @(posedge clock) begin
    if (rst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~|(channel_flag & irq_enable);
    end
  end
endmodule // proximity_threshold_param_regs

// ===== bench/prox_regs_monitor.sv
// checker for the proximity threshold bank, watching top-level ports only
// assumes one clock domain with synchronous active-high reset
module prox_regs_monitor
  import prox_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic autonomous_run,
  input wire logic [15:0] prox2_measurement,
  input wire logic prox2_measurement_valid,
  input wire logic [15:0] prox3_measurement,
  input wire logic prox3_measurement_valid,
  input wire logic [1:0] flag_clear,
  input wire logic [1:0] irq_enable,
  input wire logic [1:0] channel_flag,
  input wire logic int_n,
  input wire logic [15:0] second_channel_threshold,
  input wire logic [15:0] third_channel_threshold,
  input wire logic [7:0] parameter_write_mailbox,
  input wire logic command_strobe,
  input wire logic wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // a long high clock phase means no byte write can still be landing
  sequence bus_quiet;
    scl_in [*8];
  endsequence
  sequence hit2;
    prox2_measurement_valid && autonomous_run && (prox2_measurement > second_channel_threshold);
  endsequence
  sequence hit3;
    prox3_measurement_valid && autonomous_run && (prox3_measurement > third_channel_threshold);
  endsequence
  a_reset_values: assert property (
    $fell(rst) |-> (second_channel_threshold == RESET_WORD) && (channel_flag == 2'h0) &&
    (third_channel_threshold == RESET_WORD) && (parameter_write_mailbox == RESET_BYTE) &&
    int_n && sda_oe_n) else $error("register bank not cleared by reset");
  a_flag2_sets: assert property (hit2 |=> channel_flag[0])
    else $error("second channel flag missed an event");
  a_flag3_sets: assert property (hit3 |=> channel_flag[1])
    else $error("third channel flag missed an event");
  a_flag_holds: assert property (
    !prox2_measurement_valid && !flag_clear[0] |=> $stable(channel_flag[0]))
    else $error("second channel flag moved without cause");
  a_paused_quiet: assert property (
    !autonomous_run && (channel_flag == 2'h0) |=> channel_flag == 2'h0)
    else $error("flag set while measurements paused");
  a_int_follows: assert property (
    1'b1 |=> int_n == !(|($past(channel_flag) & $past(irq_enable))))
    else $error("interrupt pin disagrees with flags and enables");
  a_cmd_pulse: assert property (
    command_strobe || wake_request |-> (command_strobe && wake_request) ##1 !command_strobe)
    else $error("command strobe and wake not a paired single pulse");
  a_idle_bytes_hold: assert property (
    bus_quiet |=> $stable(second_channel_threshold) && $stable(third_channel_threshold) &&
    $stable(parameter_write_mailbox) && $stable(sda_oe_n)) else $error("bank changed on an idle bus");
endmodule // prox_regs_monitor
bind proximity_threshold_param_regs prox_regs_monitor u_prox_regs_monitor (
  .clock(clock),
  .rst(rst),
  .scl_in(scl_in),
  .sda_oe_n(sda_oe_n),
  .autonomous_run(autonomous_run),
  .prox2_measurement(prox2_measurement),
  .prox2_measurement_valid(prox2_measurement_valid),
  .prox3_measurement(prox3_measurement),
  .prox3_measurement_valid(prox3_measurement_valid),
  .flag_clear(flag_clear),
  .irq_enable(irq_enable),
  .channel_flag(channel_flag),
  .int_n(int_n),
  .second_channel_threshold(second_channel_threshold),
  .third_channel_threshold(third_channel_threshold),
  .parameter_write_mailbox(parameter_write_mailbox),
  .command_strobe(command_strobe),
  .wake_request(wake_request)
);

// ===== bench/host_bfm.sv
// two-wire bus host: drives the clock line and pulls the data line low
// assumes a pull-up on the data line, resolved by the enclosing bench
module host_bfm (
  input wire logic clock,
  output logic scl_in = 1'b1,
  output logic sda_drive_n = 1'b1,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // eight cycles a phase leaves margin over the bank's two-flop sampling
  localparam int HALF = 8;
  task automatic hold();
    repeat (HALF) @(negedge clock);
  endtask
  task automatic start();
    sda_drive_n = 1'b1;
    hold();
    scl_in = 1'b1;
    hold();
    sda_drive_n = 1'b0;
    hold();
    scl_in = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic stop();
    sda_drive_n = 1'b0;
    hold();
    scl_in = 1'b1;
    hold();
    sda_drive_n = 1'b1;
    hold();
  endtask
  // data moves two cycles after the clock falls so it never looks like a start
  task automatic xbit(logic b, output logic r);
    sda_drive_n = b;
    hold();
    scl_in = 1'b1;
    hold();
    r = sda_in;
    scl_in = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic wbyte(logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(b[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      b[i] = r;
    end
    xbit(nack, r);
  endtask
endmodule // host_bfm

// ===== bench/proximity_threshold_param_regs_test.sv
// self-checking bench for the proximity threshold and parameter register bank
// assumes the host model and checker are compiled before it
module proximity_threshold_param_regs_test
  import prox_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic legacy_rev_strap = 1'b0;
  logic autonomous_run = 1'b0;
  logic [15:0] prox2_measurement = 16'h0000;
  logic [15:0] prox3_measurement = 16'h0000;
  logic prox2_measurement_valid = 1'b0;
  logic prox3_measurement_valid = 1'b0;
  logic [1:0] flag_clear = 2'h0;
  logic [1:0] irq_enable = 2'h0;
  logic scl_in, sda_drive_n, sda_out, sda_oe_n, int_n, command_strobe, wake_request;
  logic [1:0] channel_flag;
  logic [15:0] second_channel_threshold, third_channel_threshold;
  logic [7:0] parameter_write_mailbox, command_value;
  logic [7:0] mirror [8'h13:8'h18];
  int n_fail = 0;
  int samples_checked = 0;
  int n_cmd = 0;
  int cycles = 0;
  // the pull-up wins wherever neither party pulls the data line low
  wire logic sda_in = sda_drive_n & (sda_oe_n | sda_out);
  host_bfm u_host_bfm (.clock, .scl_in, .sda_drive_n, .sda_in);
  proximity_threshold_param_regs u_proximity_threshold_param_regs (
    .clock(clock),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .legacy_rev_strap(legacy_rev_strap),
    .autonomous_run(autonomous_run),
    .prox2_measurement(prox2_measurement),
    .prox2_measurement_valid(prox2_measurement_valid),
    .prox3_measurement(prox3_measurement),
    .prox3_measurement_valid(prox3_measurement_valid),
    .flag_clear(flag_clear),
    .irq_enable(irq_enable),
    .channel_flag(channel_flag),
    .int_n(int_n),
    .second_channel_threshold(second_channel_threshold),
    .third_channel_threshold(third_channel_threshold),
    .parameter_write_mailbox(parameter_write_mailbox),
    .command_value(command_value),
    .command_strobe(command_strobe),
    .wake_request(wake_request)
  );
  initial forever #2 clock = ~clock;
  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    // a command counts only when the wake request pulses with it
    if (command_strobe === 1'b1 && wake_request === 1'b1)
      n_cmd++;
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [1:0] exp_flags(logic [15:0] a, logic [15:0] b);
    return {autonomous_run && (b > {mirror[8'h16], mirror[8'h15]}),
      autonomous_run && (a > {mirror[8'h14], mirror[8'h13]})};
  endfunction
  task automatic send(logic [7:0] b, logic want);
    logic k;
    u_host_bfm.wbyte(b, k);
    check("ack", {15'h0, want}, {15'h0, k});
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    u_host_bfm.start();
    send({SLAVE_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    send(d, 1'b1);
    u_host_bfm.stop();
  endtask
  task automatic set(logic [7:0] a, logic [7:0] d);
    reg_wr(a, d);
    mirror[a] = d;
  endtask
  task automatic expect_reg(string what, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    u_host_bfm.start();
    send({SLAVE_ADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
    u_host_bfm.start();
    send({SLAVE_ADDR, 1'b1}, 1'b1);
    u_host_bfm.rbyte(1'b1, d);
    u_host_bfm.stop();
    check(what, {8'h00, e}, {8'h00, d});
  endtask
  // flags are cleared first so each result stands alone
  task automatic measure(logic [15:0] a, logic [15:0] b);
    logic [1:0] f;
    flag_clear = 2'h3;
    @(negedge clock);
    flag_clear = 2'h0;
    prox2_measurement = a;
    prox3_measurement = b;
    prox2_measurement_valid = 1'b1;
    prox3_measurement_valid = 1'b1;
    @(negedge clock);
    prox2_measurement_valid = 1'b0;
    prox3_measurement_valid = 1'b0;
    f = exp_flags(a, b);
    check("channel_flag", {14'h0, f}, {14'h0, channel_flag});
    @(negedge clock);
    check("int_n", {15'h0, ~|(f & irq_enable)}, {15'h0, int_n});
  endtask
  initial begin
    logic [7:0] a;
    int c;
    void'($urandom(98));
    foreach (mirror[i])
      mirror[i] = 8'h00;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    for (int i = 'h13; i <= 'h17; i++)
      expect_reg("reset byte", 8'(i), 8'h00);
    check("sda_out", 16'h0000, {15'h0, sda_out});
    for (int i = 0; i < 10; i++) begin
      a = 8'h13 + 8'(i % 5);
      set(a, (i < 5) ? 8'hFF : 8'($urandom));
      check("second_channel_threshold", {mirror[8'h14], mirror[8'h13]}, second_channel_threshold);
      check("third_channel_threshold", {mirror[8'h16], mirror[8'h15]}, third_channel_threshold);
      check("parameter_write_mailbox", {8'h00, mirror[8'h17]}, {8'h00, parameter_write_mailbox});
      expect_reg("readback", a, mirror[a]);
    end
    reg_wr(8'h30, 8'h5A);
    expect_reg("unmapped", 8'h30, UNMAPPED_READ);
    u_host_bfm.start();
    send({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    u_host_bfm.stop();
    c = n_cmd;
    set(8'h18, 8'hC3);
    check("command pulses", 16'(c + 1), 16'(n_cmd));
    check("command_value", 16'h00C3, {8'h00, command_value});
    set(8'h13, 8'h34);
    set(8'h14, 8'h12);
    set(8'h15, 8'h00);
    set(8'h16, 8'h80);
    irq_enable = 2'h1;
    measure(16'hFFFF, 16'hFFFF);
    autonomous_run = 1'b1;
    set(8'h14, 8'h00);
    measure(16'h0035, 16'h8000);
    measure(16'h0034, 16'h8001);
    for (int i = 0; i < 16; i++) begin
      irq_enable = 2'($urandom);
      measure(16'($urandom) >> $urandom_range(15, 0), 16'($urandom));
    end
    autonomous_run = 1'b0;
    legacy_rev_strap = 1'b1;
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    reg_wr(8'h13, 8'hA5);
    reg_wr(8'h15, 8'h3C);
    reg_wr(8'h14, 8'h77);
    check("compressed second", 16'hA500, second_channel_threshold);
    check("compressed third", 16'h3C00, third_channel_threshold);
    expect_reg("legacy high byte", 8'h14, 8'h00);
    complete_run();
  end
endmodule // proximity_threshold_param_regs_test
